/* File: rtl/can_id_pkg.sv */
// Purpose: Constants shared by the message buffer identifier word store.
// Assumes: 32 buffers, 16-bit words, one clock at 100 MHz.
// Notes:   Field positions follow the two identifier word layouts.
`default_nettype none

package can_id_pkg;
    localparam int unsigned BUF_COUNT   = 32;
    localparam int unsigned BUF_IDX_W   = 5;
    localparam int unsigned WORD_W      = 16;
    // Word select: which of the two identifier words of a buffer.
    localparam logic        SEL_STD     = 1'h0;
    localparam logic        SEL_EXT     = 1'h1;
    // Standard-identifier word fields.
    localparam int unsigned STD_IDE_BIT = 0;
    localparam int unsigned STD_SRR_BIT = 1;
    localparam int unsigned STD_ID_LO   = 2;
    localparam int unsigned STD_ID_HI   = 12;
    localparam logic [15:0] STD_MASK    = 16'h1fff;
    // Extended-identifier word fields: upper extension bits 17..6 in 11..0.
    localparam int unsigned EXT_ID_LO   = 0;
    localparam int unsigned EXT_ID_HI   = 11;
    localparam logic [15:0] EXT_MASK    = 16'h0fff;
    // Access state machine.
    typedef enum logic [0:0] {ST_IDLE, ST_READ} acc_state_t;
endpackage : can_id_pkg

`default_nettype wire

/* File: rtl/can_id_word.sv */
// Purpose: One 16-bit identifier word with its implemented-bit mask.
// Assumes: Contents power up unknown; the mask is applied on write and again on read.
// Notes:   Unimplemented bits are written as zero, and the read mask makes them read as zero.
`default_nettype none

module can_id_word
    import can_id_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hffff
) (
    // Clock.
    input  wire logic        clk_sys,
    // Write port.
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    // Stored value.
    output logic      [15:0] word
);
    logic [15:0] store;
    logic [15:0] next_store;

    // Masking on the way in keeps reserved bits at zero from the first write on.
    always_comb begin
        next_store = wrEn ? (wrData & MASK) : store;
    end

    // No reset: the word is buffer memory whose contents start unknown.
    always_ff @(posedge clk_sys) begin
        store <= next_store;
    end

    // Masking again on read keeps unknown power-up bits out of reserved positions.
    assign word = store & MASK;
endmodule : can_id_word

`default_nettype wire

/* File: rtl/can_buffer_identifier_words.sv */
// Purpose: Identifier words of all message buffers in DMA-reachable buffer RAM.
// Assumes: One memory access per cycle; the engine wins a same-cycle write to a buffer.
// Notes:   Read data is registered, one cycle after the request.
`default_nettype none

module can_buffer_identifier_words
    import can_id_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // DMA / software memory port.
    input  wire logic                 memReq,
    input  wire logic                 memWrite,
    input  wire logic [BUF_IDX_W-1:0] memBuf,
    input  wire logic                 memSel,
    input  wire logic [WORD_W-1:0]    memWrData,
    output logic      [WORD_W-1:0]    memRdData,
    output logic                      memRdValid,
    // CAN engine port: reception writes, transmission reads decoded fields.
    input  wire logic                 engWrite,
    input  wire logic [BUF_IDX_W-1:0] engBuf,
    input  wire logic [10:0]          engStdId,
    input  wire logic                 engSrr,
    input  wire logic                 engIde,
    input  wire logic [11:0]          engExtIdHigh,
    input  wire logic [BUF_IDX_W-1:0] txBuf,
    output logic      [10:0]          txStdId,
    output logic                      txRemoteReq,
    output logic                      txExtended,
    output logic      [11:0]          txExtIdHigh
);
    // ***********************************************
    // Word storage
    // ***********************************************
    logic [WORD_W-1:0] stdWord [BUF_COUNT];
    logic [WORD_W-1:0] extWord [BUF_COUNT];
    logic [WORD_W-1:0] engStdWord;
    logic [WORD_W-1:0] engExtWord;

    // Pack the engine's fields into the documented word layout.
    always_comb begin
        engStdWord = '0;
        engStdWord[STD_ID_HI:STD_ID_LO] = engStdId;
        engStdWord[STD_SRR_BIT]         = engSrr;
        engStdWord[STD_IDE_BIT]         = engIde;
        engExtWord = '0;
        engExtWord[EXT_ID_HI:EXT_ID_LO] = engExtIdHigh;
    end

    // One word pair per buffer; the engine wins when both write one buffer.
    for (genvar i = 0; i < BUF_COUNT; i++) begin : g_buf
        logic memHit;
        logic engHit;
        assign memHit = memReq && memWrite && (memBuf == BUF_IDX_W'(i));
        assign engHit = engWrite && (engBuf == BUF_IDX_W'(i));
        // Kept in buffer RAM, addressed by buffer and word select.
        can_id_word #(.MASK(STD_MASK)) u_std (
            .clk_sys (clk_sys),
            .wrEn    (engHit || (memHit && memSel == SEL_STD)),
            .wrData  (engHit ? engStdWord : memWrData),
            .word    (stdWord[i])
        );
        can_id_word #(.MASK(EXT_MASK)) u_ext (
            .clk_sys (clk_sys),
            .wrEn    (engHit || (memHit && memSel == SEL_EXT)),
            .wrData  (engHit ? engExtWord : memWrData),
            .word    (extWord[i])
        );
    end

    // ***********************************************
    // Memory read port
    // ***********************************************
    acc_state_t        state;
    acc_state_t        next_state;
    logic [WORD_W-1:0] next_memRdData;

    // Reads return one cycle later; writes give no answer.
    always_comb begin
        next_memRdData = memRdData;
        next_state     = ST_IDLE;
        if (memReq && !memWrite) begin
            next_state     = ST_READ;
            next_memRdData = (memSel == SEL_STD) ? stdWord[memBuf]
                                                 : extWord[memBuf];
        end
    end

    // The answer path is reset, as are the transmit fields; the stored words keep whatever they hold.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            memRdData <= '0;
        end else begin
            state     <= next_state;
            memRdData <= next_memRdData;
        end
    end

    // The valid flag comes straight from the state, so it stands one cycle for each read request.
    assign memRdValid = (state == ST_READ);

    // ***********************************************
    // Transmit field decode
    // ***********************************************
    logic [10:0] next_txStdId;
    logic        next_txRemoteReq;
    logic        next_txExtended;
    logic [11:0] next_txExtIdHigh;

    // Registered so the engine sees stable fields one cycle after txBuf.
    always_comb begin
        next_txStdId     = stdWord[txBuf][STD_ID_HI:STD_ID_LO];
        next_txRemoteReq = stdWord[txBuf][STD_SRR_BIT];
        next_txExtended  = stdWord[txBuf][STD_IDE_BIT];
        next_txExtIdHigh = extWord[txBuf][EXT_ID_HI:EXT_ID_LO];
    end

    // Reset clears the fields; once it lifts they follow the words, which stay unknown until written.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txStdId     <= '0;
            txRemoteReq <= 1'b0;
            txExtended  <= 1'b0;
            txExtIdHigh <= '0;
        end else begin
            txStdId     <= next_txStdId;
            txRemoteReq <= next_txRemoteReq;
            txExtended  <= next_txExtended;
            txExtIdHigh <= next_txExtIdHigh;
        end
    end

    // ***********************************************
    // Assertions
    // ***********************************************
    property p_ext_upper_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        memRdValid && $past(memSel) == SEL_EXT |-> memRdData[15:12] == 4'h0;
    endproperty
    a_ext_upper_zero: assert property (p_ext_upper_zero)
        else $error("Extended word upper bits not zero.");

    property p_std_upper_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        memRdValid |-> memRdData[15:13] == 3'h0;
    endproperty
    a_std_upper_zero: assert property (p_std_upper_zero)
        else $error("Identifier word upper bits not zero.");

    property p_srr_roundtrip;
        @(posedge clk_sys) disable iff (!rst_n)
        memReq && memWrite && memSel == SEL_STD && !engWrite && txBuf == memBuf
        ##1 txBuf == $past(txBuf) |-> ##1 txRemoteReq == $past(memWrData[1], 2);
    endproperty
    a_srr_roundtrip: assert property (p_srr_roundtrip)
        else $error("Remote request flag not taken from bit 1.");

    property p_ide_roundtrip;
        @(posedge clk_sys) disable iff (!rst_n)
        memReq && memWrite && memSel == SEL_STD && !engWrite && txBuf == memBuf
        ##1 txBuf == $past(txBuf) |-> ##1 txExtended == $past(memWrData[0], 2);
    endproperty
    a_ide_roundtrip: assert property (p_ide_roundtrip)
        else $error("Format select not taken from bit 0.");

    // Engine round trips: the word lands at the write edge and the registered
    // transmit fields show it one edge later, as long as txBuf stays put.
    property p_ext_roundtrip;
        @(posedge clk_sys) disable iff (!rst_n)
        engWrite && txBuf == engBuf ##1 txBuf == $past(txBuf)
        |-> ##1 txExtIdHigh == $past(engExtIdHigh, 2);
    endproperty
    a_ext_roundtrip: assert property (p_ext_roundtrip)
        else $error("Extension bits not stored in bits 11 to 0.");

    property p_std_id_roundtrip;
        @(posedge clk_sys) disable iff (!rst_n)
        engWrite && txBuf == engBuf ##1 txBuf == $past(txBuf)
        |-> ##1 txStdId == $past(engStdId, 2);
    endproperty
    a_std_id_roundtrip: assert property (p_std_id_roundtrip)
        else $error("Standard identifier not stored in bits 12 to 2.");

    property p_eng_flags;
        @(posedge clk_sys) disable iff (!rst_n)
        engWrite && txBuf == engBuf ##1 txBuf == $past(txBuf)
        |-> ##1 {txRemoteReq, txExtended} == $past({engSrr, engIde}, 2);
    endproperty
    a_eng_flags: assert property (p_eng_flags)
        else $error("Received flags not stored in bits 1 and 0.");

    property p_read_latency;
        @(posedge clk_sys) disable iff (!rst_n)
        memReq && !memWrite |=> memRdValid;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("Buffer RAM read not answered after one cycle.");

    // Read data must not drift between reads, since software may sample it late.
    property p_rd_data_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !(memReq && !memWrite) |=> $stable(memRdData);
    endproperty
    a_rd_data_hold: assert property (p_rd_data_hold)
        else $error("Buffer RAM read data changed without a read.");

    property p_write_silent;
        @(posedge clk_sys) disable iff (!rst_n)
        memReq && memWrite |=> !memRdValid;
    endproperty
    a_write_silent: assert property (p_write_silent)
        else $error("Buffer RAM write produced a read answer.");

    // Main scenarios: reads of each word, engine writes, remote frames, collisions.
    c_read_std: cover property (@(posedge clk_sys) memRdValid && $past(memSel) == SEL_STD);
    c_read_ext: cover property (@(posedge clk_sys) memRdValid && $past(memSel) == SEL_EXT);
    c_collision: cover property (@(posedge clk_sys)
        engWrite && memReq && memWrite && engBuf == memBuf);
    c_eng_write: cover property (@(posedge clk_sys) engWrite && engIde);
    c_remote: cover property (@(posedge clk_sys) txRemoteReq && txExtended);
endmodule : can_buffer_identifier_words

`default_nettype wire

/* File: testbench/can_engine_model.sv */
// Purpose: Behavioural CAN engine that writes received identifiers into buffers.
// Assumes: Driven from the bench by calling recv; one write per call.
// Notes:   Fields are scrambled after each pulse so stale values never match.
`default_nettype none

module can_engine_model
    import can_id_pkg::*;
(
    // Clock.
    input  wire logic                 clk_sys,
    // Reception write port.
    output var  logic                 engWrite,
    output var  logic [BUF_IDX_W-1:0] engBuf,
    output var  logic [10:0]          engStdId,
    output var  logic                 engSrr,
    output var  logic                 engIde,
    output var  logic [11:0]          engExtIdHigh
);
    timeunit 1ns;
    timeprecision 1ps;

    // The port is idle at time zero.
    initial begin
        {engWrite, engBuf, engStdId, engSrr, engIde, engExtIdHigh} = '0;
    end

    // One-cycle write pulse; afterwards the fields are inverted as if released.
    task automatic recv(input logic [4:0] b, input logic [10:0] s, input logic r,
                        input logic i, input logic [11:0] e);
        @(posedge clk_sys);
        {engWrite, engBuf, engStdId, engSrr, engIde, engExtIdHigh} <= {1'b1, b, s, r, i, e};
        @(posedge clk_sys);
        {engWrite, engBuf, engStdId, engSrr, engIde, engExtIdHigh} <= {1'b0, ~b, ~s, ~r, ~i, ~e};
    endtask : recv
endmodule : can_engine_model

`default_nettype wire

/* File: testbench/can_buffer_identifier_words_tb.sv */
// Purpose: Self-checking bench for the buffer identifier word store.
// Assumes: Reads answer one cycle after the request; tx fields lag txBuf by one.
// Notes:   Each access takes two cycles so a strobe is never set twice at one edge.
`default_nettype none
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin badCount++; \
    $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); end end

module can_buffer_identifier_words_tb
    import can_id_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, rst_n, memReq, memWrite, memSel, memRdValid;
    logic        engWrite, engSrr, engIde, txRemoteReq, txExtended;
    logic [4:0]  memBuf, engBuf, txBuf;
    logic [15:0] memWrData, memRdData;
    logic [10:0] engStdId, txStdId;
    logic [11:0] engExtIdHigh, txExtIdHigh;
    int          badCount, checkCount;
    logic [15:0] stdVal [4] = '{16'hffff, 16'h0abe, 16'h0541, 16'he000};
    logic [15:0] extVal [4] = '{16'hffff, 16'ha5c3, 16'h0000, 16'h5a3c};
    logic [4:0]  bufVal [4] = '{5'h00, 5'h05, 5'h11, 5'h1f};

    // Design under test and the engine that writes received frames into it.
    can_buffer_identifier_words can_buffer_identifier_words_inst (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .memReq       (memReq),
        .memWrite     (memWrite),
        .memBuf       (memBuf),
        .memSel       (memSel),
        .memWrData    (memWrData),
        .memRdData    (memRdData),
        .memRdValid   (memRdValid),
        .engWrite     (engWrite),
        .engBuf       (engBuf),
        .engStdId     (engStdId),
        .engSrr       (engSrr),
        .engIde       (engIde),
        .engExtIdHigh (engExtIdHigh),
        .txBuf        (txBuf),
        .txStdId      (txStdId),
        .txRemoteReq  (txRemoteReq),
        .txExtended   (txExtended),
        .txExtIdHigh  (txExtIdHigh)
    );
    can_engine_model can_engine_model_inst (
        .clk_sys      (clk_sys),
        .engWrite     (engWrite),
        .engBuf       (engBuf),
        .engStdId     (engStdId),
        .engSrr       (engSrr),
        .engIde       (engIde),
        .engExtIdHigh (engExtIdHigh)
    );

    // The clock toggles every 5 ns, for a period of 10 ns.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // One memory access; data is inverted afterwards so stale values never pass.
    task automatic memAccess(input logic wr, input logic [4:0] b, input logic s,
                             input logic [15:0] d);
        @(posedge clk_sys);
        {memReq, memWrite, memBuf, memSel, memWrData} <= {1'b1, wr, b, s, d};
        @(posedge clk_sys);
        {memReq, memWrData} <= {1'b0, ~d};
    endtask : memAccess

    // Read one word and compare it in the single cycle its answer stands.
    task automatic rdChk(input logic [4:0] b, input logic s, input logic [15:0] exp);
        memAccess(1'b0, b, s, 16'h0000);
        #1;
        `CHK(memRdValid, 1'b1)
        `CHK(memRdData, exp)
    endtask : rdChk

    // Point the transmit side at a buffer and let its registered fields settle.
    task automatic txSee(input logic [4:0] b);
        @(posedge clk_sys);
        txBuf <= b;
        @(posedge clk_sys);
        #1;
    endtask : txSee

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : printVerdict

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (5000) @(posedge clk_sys);
        badCount++;
        printVerdict();
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {rst_n, memReq, memWrite, memSel, memBuf, txBuf, memWrData} = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        `CHK({memRdValid, memRdData}, 17'h00000)
        `CHK({txStdId, txRemoteReq, txExtended, txExtIdHigh}, 25'h0000000)
        // Full patterns, all four flag codes and all-zero fields across the buffer range.
        for (int k = 0; k < 4; k++) begin
            memAccess(1'b1, bufVal[k], SEL_STD, stdVal[k]);
            memAccess(1'b1, bufVal[k], SEL_EXT, extVal[k]);
            rdChk(bufVal[k], SEL_STD, stdVal[k] & 16'h1fff);
            rdChk(bufVal[k], SEL_EXT, extVal[k] & 16'h0fff);
            txSee(bufVal[k]);
            `CHK({txStdId, txRemoteReq, txExtended}, stdVal[k][12:0])
            `CHK(txExtIdHigh, extVal[k][11:0])
        end
        // A received frame lands in the same words that the memory port reads.
        // The transmit side points at the buffer first so its fields follow the write.
        txSee(5'h09);
        can_engine_model_inst.recv(5'h09, 11'h5a5, 1'b1, 1'b0, 12'hc3a);
        rdChk(5'h09, SEL_STD, 16'h1696);
        rdChk(5'h09, SEL_EXT, 16'h0c3a);
        `CHK({txStdId, txRemoteReq, txExtended}, 13'h1696)
        `CHK(txExtIdHigh, 12'hc3a)
        // Engine and memory writing one buffer in the same cycle: engine wins.
        txSee(5'h0c);
        fork
            can_engine_model_inst.recv(5'h0c, 11'h001, 1'b0, 1'b1, 12'h001);
            memAccess(1'b1, 5'h0c, SEL_STD, 16'h1ffe);
        join
        rdChk(5'h0c, SEL_STD, 16'h0005);
        rdChk(5'h0c, SEL_EXT, 16'h0001);
        `CHK({txStdId, txRemoteReq, txExtended}, 13'h0005)
        `CHK(txExtIdHigh, 12'h001)
        printVerdict();
    end
endmodule : can_buffer_identifier_words_tb

`default_nettype wire
